// ### logic/uvf_map.svh
`ifndef UVF_MAP_SVH
`define UVF_MAP_SVH

`define UVF_CMD_CLEAR    8'h03
`define UVF_CMD_THR      8'h59
`define UVF_CMD_ACT      8'h5a
`define UVF_CMD_STATUS   8'h7c
`define UVF_CMD_UNIT     8'hc8
`define UVF_STAT_BIT     4
`define UVF_THR_RST      16'h0000
`define UVF_ACT_RST      8'h00
`define UVF_ACT_MODE_HI  7
`define UVF_ACT_MODE_LO  6
`define UVF_ACT_TRY_HI   5
`define UVF_ACT_TRY_LO   3
`define UVF_ACT_DLY_HI   2
`define UVF_ACT_DLY_LO   0
`define UVF_TRY_ENDLESS  3'h7
`define UVF_UNIT_W       20
`define UVF_TMR_W        28

`endif

// ### logic/uvf_pkg.sv
`include "uvf_map.svh"

package uvf_pkg;

    typedef struct packed {
        logic        write;
        logic [7:0]  code;
        logic [15:0] wdata;
    } uvf_cmd_t;

    typedef struct packed {
        logic [7:0]  act;
        logic [15:0] thr;
    } uvf_cfg_t;

    typedef enum logic [2:0] {
        S_RUN,
        S_DELAY,
        S_HOLD,
        S_TRY,
        S_LATCH
    } uvf_state_t;

endpackage

// ### logic/uvf_sync.sv
`timescale 1ns/10ps

// Three-stage synchroniser; the output moves once stages two and three agree.
module uvf_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    always_ff @(posedge clk) begin
        s1_reg <= d;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else if (s2_reg == s3_reg) begin
            q <= s3_reg;
        end
    end
endmodule // uvf_sync

// ### logic/uvf_top.sv
`timescale 1ns/10ps
`include "uvf_map.svh"

module uvf_top
    import uvf_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire logic                    lk_clk,
    input  wire logic                    lk_valid,
    input  wire uvf_cmd_t                lk_cmd,
    output logic      [15:0]             lk_rdata,
    output logic                         lk_rvalid,
    input  wire logic [15:0]             vin_meas,
    input  wire logic [`UVF_UNIT_W-1:0]  unit_cycles,
    input  wire logic                    op_on,
    input  wire logic                    ctrl_pin,
    output logic                         out_enable,
    output logic                         uv_fault
);
    logic                    lk_rst_n;
    uvf_cfg_t                lk_cfg_reg;
    logic                    lk_clr_tgl_reg;
    logic                    lk_fault_s;
    uvf_cfg_t                cfg;
    logic                    clr_tgl_s;
    logic                    clr_tgl_q;
    logic                    ctrl_s;
    logic                    cmd_on_q;
    logic                    cmd_on;
    logic                    on_rise;
    logic                    clr_evt;
    logic                    clr;
    logic                    uv;
    logic [1:0]              mode;
    logic [2:0]              retries;
    logic [2:0]              dly_code;
    logic [`UVF_UNIT_W-1:0]  unit_eff;
    logic [`UVF_TMR_W-1:0]   dly_m1;
    logic [`UVF_TMR_W-1:0]   tmr_reg;
    logic                    tmr_done;
    logic [2:0]              tries_reg;
    logic                    try_spent;
    uvf_state_t              state_reg;
    uvf_state_t              state_next;
    logic                    start_tmr;

    // Linear word to a common fixed-point scale: 11-bit mantissa times 2 to the exponent.
    function automatic logic signed [47:0] lin_fix(input logic [15:0] v);
        logic [4:0] sh;
        sh = v[15:11] ^ 5'h10;
        lin_fix = $signed({{37{v[10]}}, v[10:0]}) <<< sh;
    endfunction

    // Link domain.
    uvf_sync #(.W(1)) u_lk_rst (.clk(lk_clk), .rst_n(1'b1), .d(reset_n), .q(lk_rst_n));

    always_ff @(posedge lk_clk) begin
        if (!lk_rst_n) begin
            lk_cfg_reg.thr <= `UVF_THR_RST;
            lk_cfg_reg.act <= `UVF_ACT_RST;
        end else if (lk_valid && lk_cmd.write) begin
            if (lk_cmd.code == `UVF_CMD_THR) begin
                lk_cfg_reg.thr <= lk_cmd.wdata;
            end
            if (lk_cmd.code == `UVF_CMD_ACT) begin
                lk_cfg_reg.act <= lk_cmd.wdata[7:0];
            end
        end
    end

    // A clear command, or a one written to the fault bit, flips the clear toggle.
    always_ff @(posedge lk_clk) begin
        if (!lk_rst_n) begin
            lk_clr_tgl_reg <= 1'b0;
        end else if (lk_valid && lk_cmd.write &&
                     ((lk_cmd.code == `UVF_CMD_CLEAR) ||
                      ((lk_cmd.code == `UVF_CMD_STATUS) && lk_cmd.wdata[`UVF_STAT_BIT]))) begin
            lk_clr_tgl_reg <= ~lk_clr_tgl_reg;
        end
    end

    always_ff @(posedge lk_clk) begin
        if (!lk_rst_n) begin
            lk_rdata  <= 16'h0000;
            lk_rvalid <= 1'b0;
        end else begin
            lk_rvalid <= lk_valid && !lk_cmd.write;
            unique case (lk_cmd.code)
                `UVF_CMD_THR:    lk_rdata <= lk_cfg_reg.thr;
                `UVF_CMD_ACT:    lk_rdata <= {8'h00, lk_cfg_reg.act};
                `UVF_CMD_STATUS: lk_rdata <= 16'(lk_fault_s) << `UVF_STAT_BIT;
                default:         lk_rdata <= 16'h0000;
            endcase
        end
    end

    uvf_sync #(.W(1)) u_lk_stat (.clk(lk_clk), .rst_n(lk_rst_n), .d(uv_fault), .q(lk_fault_s));

    // Crossings into the core domain.
    uvf_xfer #(.W(24), .RST({`UVF_ACT_RST, `UVF_THR_RST})) u_cfg (
        .src_clk   (lk_clk),
        .src_rst_n (lk_rst_n),
        .src_data  (lk_cfg_reg),
        .dst_clk   (clk),
        .dst_rst_n (reset_n),
        .dst_data  (cfg)
    );

    uvf_sync #(.W(1)) u_clr  (.clk(clk), .rst_n(reset_n), .d(lk_clr_tgl_reg), .q(clr_tgl_s));
    uvf_sync #(.W(1)) u_ctrl (.clk(clk), .rst_n(reset_n), .d(ctrl_pin), .q(ctrl_s));

    // Core domain decode.
    assign mode     = cfg.act[`UVF_ACT_MODE_HI:`UVF_ACT_MODE_LO];
    assign retries  = cfg.act[`UVF_ACT_TRY_HI:`UVF_ACT_TRY_LO];
    assign dly_code = cfg.act[`UVF_ACT_DLY_HI:`UVF_ACT_DLY_LO];
    assign unit_eff = (unit_cycles == '0) ? `UVF_UNIT_W'(1) : unit_cycles;
    assign dly_m1   = (`UVF_TMR_W'(unit_eff) << dly_code) - `UVF_TMR_W'(1);
    assign uv       = lin_fix(vin_meas) < lin_fix(cfg.thr);
    assign cmd_on   = op_on && ctrl_s;
    assign on_rise  = cmd_on && !cmd_on_q;
    assign clr_evt  = (clr_tgl_s != clr_tgl_q);
    assign clr      = clr_evt || on_rise || !cmd_on;
    assign tmr_done = (tmr_reg == '0);
    assign try_spent = (retries != `UVF_TRY_ENDLESS) && (tries_reg >= retries);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            clr_tgl_q <= 1'b0;
            cmd_on_q  <= 1'b0;
        end else begin
            clr_tgl_q <= clr_tgl_s;
            cmd_on_q  <= cmd_on;
        end
    end

    always_comb begin
        state_next = state_reg;
        if (clr) begin
            state_next = S_RUN;
        end else begin
            unique case (state_reg)
                S_RUN: begin
                    if (uv) begin
                        unique case (mode)
                            2'b00: state_next = S_RUN;
                            2'b01: state_next = S_DELAY;
                            2'b10: state_next = (retries == 3'h0) ? S_LATCH : S_HOLD;
                            2'b11: state_next = S_LATCH;
                        endcase
                    end
                end
                S_DELAY: begin
                    if (!uv) begin
                        state_next = S_RUN;
                    end else if (tmr_done) begin
                        state_next = (retries == 3'h0) ? S_LATCH : S_HOLD;
                    end
                end
                S_HOLD: begin
                    if (tmr_done) begin
                        state_next = S_TRY;
                    end
                end
                S_TRY: begin
                    if (uv) begin
                        state_next = try_spent ? S_LATCH : S_HOLD;
                    end else if (tmr_done) begin
                        state_next = S_RUN;
                    end
                end
                S_LATCH: state_next = S_LATCH;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= S_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // The timer restarts at each attempt start so attempts sit one delay apart, or two cycles apart when the delay is one cycle.
    assign start_tmr = ((state_reg == S_RUN) && uv && (mode == 2'b01 || mode == 2'b10)) ||
                       ((state_reg == S_DELAY) && uv && tmr_done) ||
                       ((state_reg == S_HOLD) && tmr_done);

    always_ff @(posedge clk) begin
        if (!reset_n || clr) begin
            tmr_reg <= '0;
        end else if (start_tmr) begin
            tmr_reg <= dly_m1;
        end else if (!tmr_done) begin
            tmr_reg <= tmr_reg - `UVF_TMR_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n || clr || state_reg == S_RUN) begin
            tries_reg <= 3'h0;
        end else if (state_reg == S_HOLD && tmr_done && tries_reg != 3'h7) begin
            tries_reg <= tries_reg + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            out_enable <= 1'b0;
        end else begin
            out_enable <= cmd_on && (state_next == S_RUN || state_next == S_DELAY ||
                                     state_next == S_TRY);
        end
    end

    // The fault flag is sticky; a new fault in the clearing cycle wins.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            uv_fault <= 1'b0;
        end else if (uv) begin
            uv_fault <= 1'b1;
        end else if (clr_evt || on_rise) begin
            uv_fault <= 1'b0;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_uv_flag_set: assert property (uv |=> uv_fault)
        else $error("fault flag not set on undervoltage");
    a_ignore_keeps_on: assert property (
        state_reg == S_RUN && mode == 2'b00 && cmd_on && !clr |=> out_enable)
        else $error("ignore mode dropped the output");
    a_delay_load: assert property (
        state_reg == S_RUN && uv && mode == 2'b01 && !clr
        |=> state_reg == S_DELAY && out_enable && tmr_reg == $past(dly_m1))
        else $error("run-on delay not started");
    a_delay_runs_on: assert property (
        state_reg == S_DELAY && uv && !tmr_done && !clr
        |=> state_reg == S_DELAY && out_enable)
        else $error("run-on delay cut short");
    a_disable_now: assert property (
        state_reg == S_RUN && uv && mode == 2'b10 && !clr |=> !out_enable)
        else $error("output not disabled at once");
    a_latch_holds: assert property (
        state_reg == S_LATCH && !clr |=> state_reg == S_LATCH && !out_enable)
        else $error("latched fault released without clear");
    a_flag_sticky: assert property (
        uv_fault && !clr_evt && !on_rise |=> uv_fault)
        else $error("fault flag dropped without clear");
    a_clear_drops_flag: assert property (
        (clr_evt || on_rise) && !uv |=> !uv_fault)
        else $error("fault flag survived a clear");
    a_cycle_clears: assert property (on_rise |=> state_reg == S_RUN ##0 tries_reg == 3'h0)
        else $error("off-on cycle did not clear");
    a_no_retry: assert property (
        state_reg == S_DELAY && uv && tmr_done && retries == 3'h0 && !clr
        |=> state_reg == S_LATCH)
        else $error("retry 000 did not latch");
    a_try_limit: assert property (
        state_reg == S_TRY && uv && try_spent && !clr
        |=> state_reg == S_LATCH ##1 (state_reg == S_LATCH || $past(clr)))
        else $error("attempt limit not enforced");
    a_try_spacing: assert property (
        state_reg == S_HOLD && tmr_done && !clr
        |=> state_reg == S_TRY && tmr_reg == $past(dly_m1))
        else $error("attempt spacing wrong");
    a_try_turns_on: assert property (
        state_reg == S_HOLD && tmr_done && !clr |=> out_enable)
        else $error("restart attempt left output off");
    a_endless: assert property (
        state_reg == S_TRY && uv && retries == 3'h7 && !clr |=> state_reg == S_HOLD)
        else $error("endless retry stopped");
    a_off_blocks_out: assert property (!cmd_on |=> !out_enable)
        else $error("output on while commanded off");
    a_fresh_count: assert property (
        state_reg == S_RUN ##1 state_reg != S_RUN |-> tries_reg == 3'h0)
        else $error("attempt count not fresh");
    a_thr_store: assert property (@(posedge lk_clk) disable iff (!lk_rst_n)
        lk_valid && lk_cmd.write && lk_cmd.code == `UVF_CMD_THR
        |=> lk_cfg_reg.thr == $past(lk_cmd.wdata))
        else $error("threshold write lost");
    a_act_store: assert property (@(posedge lk_clk) disable iff (!lk_rst_n)
        lk_valid && lk_cmd.write && lk_cmd.code == `UVF_CMD_ACT
        |=> lk_cfg_reg.act == 8'($past(lk_cmd.wdata)))
        else $error("response write lost");
    a_read_answer: assert property (@(posedge lk_clk) disable iff (!lk_rst_n)
        lk_valid && !lk_cmd.write |=> lk_rvalid)
        else $error("read not answered");

endmodule // uvf_top

// ### logic/uvf_xfer.sv
`timescale 1ns/10ps

// Mirrors a word from one clock domain into another by a toggle handshake.
module uvf_xfer #(
    parameter int           W   = 8,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         src_clk,
    input  wire logic         src_rst_n,
    input  wire logic [W-1:0] src_data,
    input  wire logic         dst_clk,
    input  wire logic         dst_rst_n,
    output logic      [W-1:0] dst_data
);
    logic [W-1:0] hold_reg;
    logic         req_reg;
    logic         ack_reg;
    logic         req_s;
    logic         ack_s;
    logic         busy;

    assign busy = (req_reg != ack_s);

    always_ff @(posedge src_clk) begin
        if (!src_rst_n) begin
            hold_reg <= RST;
            req_reg  <= 1'b0;
        end else if (!busy && (src_data != hold_reg)) begin
            hold_reg <= src_data;
            req_reg  <= ~req_reg;
        end
    end

    uvf_sync #(.W(1)) u_ack (.clk(src_clk), .rst_n(src_rst_n), .d(ack_reg), .q(ack_s));
    uvf_sync #(.W(1)) u_req (.clk(dst_clk), .rst_n(dst_rst_n), .d(req_reg), .q(req_s));

    // The hold word stays still while a request is open, so it is safe to sample here.
    always_ff @(posedge dst_clk) begin
        if (!dst_rst_n) begin
            dst_data <= RST;
            ack_reg  <= 1'b0;
        end else if (req_s != ack_reg) begin
            dst_data <= hold_reg;
            ack_reg  <= req_s;
        end
    end
endmodule // uvf_xfer

// ### sim/input_uv_fault_response_test.sv
`timescale 1ns/10ps
`include "uvf_map.svh"

module input_uv_fault_response_test import uvf_pkg::*;;
    localparam logic [15:0] VIN_OK  = 16'h00c8;
    localparam logic [15:0] VIN_LOW = 16'h0032;
    localparam logic [15:0] THR     = 16'h0064;

    logic                   clk = 1'b0;
    logic                   lk_clk = 1'b0;
    logic                   reset_n;
    logic                   lk_valid;
    uvf_cmd_t               lk_cmd;
    logic [15:0]            lk_rdata;
    logic                   lk_rvalid;
    logic [15:0]            vin_meas;
    logic [`UVF_UNIT_W-1:0] unit_cycles;
    logic                   op_on;
    logic                   ctrl_pin;
    logic                   out_enable;
    logic                   uv_fault;
    logic                   prev_en = 1'b0;
    int                     err_count = 0;
    int                     comparisons = 0;
    int                     cyc = 0;
    int                     rises[$];

    always #25 clk = ~clk;
    initial begin
        #37;
        forever #80 lk_clk = ~lk_clk;
    end

    uvf_top dut_u (.clk(clk), .reset_n(reset_n), .lk_clk(lk_clk), .lk_valid(lk_valid),
        .lk_cmd(lk_cmd), .lk_rdata(lk_rdata), .lk_rvalid(lk_rvalid), .vin_meas(vin_meas),
        .unit_cycles(unit_cycles), .op_on(op_on), .ctrl_pin(ctrl_pin),
        .out_enable(out_enable), .uv_fault(uv_fault));
    uvf_host u_host (.lk_clk(lk_clk), .lk_valid(lk_valid), .lk_cmd(lk_cmd),
        .lk_rdata(lk_rdata), .lk_rvalid(lk_rvalid));

    // Records the cycle of every output turn-on and cuts a hang short.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (out_enable === 1'b1 && prev_en === 1'b0) rises.push_back(cyc);
        prev_en <= out_enable;
        if (cyc == 40000) begin
            err_count++;
            $display("[ERR] %0t run timed out", $time);
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("err_count=%0d comparisons=%0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp, input string what);
        check_word({15'h0000, got}, {15'h0000, exp}, what);
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic reg_rd(input logic [7:0] code, input logic [15:0] exp);
        logic [15:0] d;
        logic        ok;
        u_host.read(code, d, ok);
        check_bit(ok, 1'b1, "read answer");
        check_word(d, exp, "read data");
    endtask

    task automatic set_act(input logic [7:0] a);
        u_host.write(`UVF_CMD_ACT, {8'h00, a});
        wait_clk(40);
    endtask

    task automatic recover();
        vin_meas = VIN_OK;
        wait_clk(5);
        u_host.write(`UVF_CMD_CLEAR, 16'h0000);
        wait_clk(40);
        check_bit(uv_fault, 1'b0, "flag after clear");
        check_bit(out_enable, 1'b1, "output after clear");
    endtask

    task automatic t_regs();
        reg_rd(`UVF_CMD_THR, `UVF_THR_RST);
        reg_rd(`UVF_CMD_ACT, {8'h00, `UVF_ACT_RST});
        u_host.write(`UVF_CMD_THR, THR);
        u_host.write(`UVF_CMD_ACT, 16'h00a5);
        reg_rd(`UVF_CMD_THR, THR);
        reg_rd(`UVF_CMD_ACT, 16'h00a5);
        reg_rd(8'h10, 16'h0000);
        set_act(8'h00);
        $display("registers test done");
    endtask

    task automatic t_ignore();
        rises.delete();
        vin_meas = VIN_LOW;
        wait_clk(60);
        check_bit(uv_fault, 1'b1, "flag on low input");
        check_bit(out_enable, 1'b1, "ignore keeps output");
        check_word(rises.size(), 0, "no interruption");
        recover();
        $display("ignore test done");
    endtask

    task automatic t_no_retry(input logic [7:0] a, input int on_cycles);
        logic [15:0] d;
        logic        ok;
        set_act(a);
        rises.delete();
        vin_meas = VIN_LOW;
        wait_clk(on_cycles);
        check_bit(out_enable, (on_cycles > 3) ? 1'b1 : 1'b0, "early output");
        wait_clk(30);
        check_bit(out_enable, 1'b0, "output off");
        vin_meas = VIN_OK;
        wait_clk(100);
        check_bit(out_enable, 1'b0, "stays latched");
        check_word(rises.size(), 0, "no restart");
        u_host.read(`UVF_CMD_STATUS, d, ok);
        check_bit(ok, 1'b1, "status answer");
        check_bit(d[`UVF_STAT_BIT], 1'b1, "status bit");
        u_host.write(`UVF_CMD_STATUS, 16'h0010);
        wait_clk(40);
        check_bit(uv_fault, 1'b0, "bit clear");
        check_bit(out_enable, 1'b1, "bit clear output");
        $display("no retry test done");
    endtask

    task automatic t_runon_recovers();
        set_act(8'h43);
        rises.delete();
        vin_meas = VIN_LOW;
        wait_clk(6);
        vin_meas = VIN_OK;
        wait_clk(60);
        check_bit(out_enable, 1'b1, "run on survives");
        check_word(rises.size(), 0, "never dropped");
        recover();
        $display("run on test done");
    endtask

    task automatic count_tries(input int n, input int dly, input string what);
        check_word(rises.size(), n, what);
        for (int i = 1; i < rises.size(); i++)
            check_word(rises[i] - rises[i-1], dly, "spacing");
    endtask

    task automatic t_retry(input logic [7:0] a, input int unit, input int n);
        int dly;
        dly = unit << a[2:0];
        unit_cycles = unit;
        set_act(a);
        rises.delete();
        vin_meas = VIN_LOW;
        wait_clk((n + 2) * dly + 20);
        count_tries(n, dly, "tries");
        check_bit(out_enable, 1'b0, "off after tries");
        op_on = 1'b0;
        wait_clk(10);
        op_on = 1'b1;
        // The turn-on cycle re-detects the fault and shows one short pulse, not an attempt.
        wait_clk(3);
        rises.delete();
        wait_clk((n + 2) * dly + 20);
        count_tries(n, dly, "tries after on");
        recover();
        $display("retry test done");
    endtask

    task automatic t_endless();
        int dly;
        dly = 3 << 1;
        unit_cycles = 3;
        set_act(8'hb9);
        vin_meas = VIN_LOW;
        wait_clk(20);
        rises.delete();
        wait_clk(10 * dly + 3);
        count_tries(10, dly, "endless tries");
        ctrl_pin = 1'b0;
        wait_clk(20);
        rises.delete();
        wait_clk(5 * dly);
        check_word(rises.size(), 0, "off by pin");
        check_bit(out_enable, 1'b0, "pin off output");
        vin_meas = VIN_OK;
        ctrl_pin = 1'b1;
        wait_clk(20);
        recover();
        $display("endless test done");
    endtask

    initial begin
        reset_n     = 1'b0;
        vin_meas    = VIN_OK;
        unit_cycles = 2;
        op_on       = 1'b1;
        ctrl_pin    = 1'b1;
        repeat (18) @(negedge clk);
        reset_n = 1'b1;
        wait_clk(20);
        t_regs();
        t_ignore();
        t_no_retry(8'h81, 2);
        t_no_retry(8'hc1, 2);
        t_no_retry(8'h43, 8);
        t_runon_recovers();
        t_retry(8'h92, 2, 2);
        t_retry(8'hb0, 3, 6);
        t_endless();
        print_verdict();
    end
endmodule // input_uv_fault_response_test

// ### sim/uvf_host.sv
`timescale 1ns/10ps

// Link-side host: commands change on the falling edge and are taken on the next rising edge.
module uvf_host
    import uvf_pkg::*;
(
    input  wire logic        lk_clk,
    output logic             lk_valid,
    output uvf_cmd_t         lk_cmd,
    input  wire logic [15:0] lk_rdata,
    input  wire logic        lk_rvalid
);
    initial begin
        lk_valid = 1'b0;
        lk_cmd   = '0;
    end

    task automatic put(input logic wr, input logic [7:0] code, input logic [15:0] data);
        @(negedge lk_clk);
        lk_valid = 1'b1;
        lk_cmd   = '{write: wr, code: code, wdata: data};
        @(posedge lk_clk);
    endtask

    // Released command lines show the inverse of the last value.
    task automatic drop();
        lk_valid = 1'b0;
        lk_cmd   = ~lk_cmd;
    endtask

    task automatic write(input logic [7:0] code, input logic [15:0] data);
        put(1'b1, code, data);
        @(negedge lk_clk);
        drop();
    endtask

    task automatic read(input logic [7:0] code, output logic [15:0] data, output logic ok);
        ok   = 1'b0;
        data = 'x;
        put(1'b0, code, 16'h0000);
        for (int i = 0; i < 2; i++) begin
            @(negedge lk_clk);
            if (i == 0) drop();
            if (lk_rvalid === 1'b1 && !ok) begin
                ok   = 1'b1;
                data = lk_rdata;
            end
        end
    endtask
endmodule // uvf_host
